// ### hw/fswp_top.sv
// Purpose: status byte, write latch and protection logic of a serial flash
// Assumes: host keeps the serial clock low while select is high
// Notes: frame fields are read in the system domain only after select rises
`timescale 1ns/10ps
`default_nettype none
module fswp_top #(
	parameter int unsigned TW_CYCLES = fswp_pkg::TW_CYC
) (
	input  wire logic       SYS_CLK,
	input  wire logic       ARST_N,
	input  wire logic       SPI_CLK,
	input  wire logic       CS_N,
	input  wire logic       SERIAL_IN,
	output logic            SERIAL_OUT,
	output logic            SERIAL_OUT_OE_N,
	input  wire logic       LOCK_PIN_N,
	input  wire logic       ARRAY_REQ,
	input  wire logic [2:0] ARRAY_KIND,
	input  wire logic       ARRAY_IN_GUARD,
	input  wire logic       ARRAY_DONE,
	output logic            ARRAY_GRANT,
	output logic            ARRAY_REFUSE,
	output logic            WRITE_LATCH,
	output logic            WRITE_BUSY,
	output logic [1:0]      GUARD_SIZE,
	output logic            HARD_LOCK
);
	// link domain
	fswp_pkg::fswp_frame_t frame_ff;
	logic [6:0]            sh_ff;
	logic                  first_ff;
	logic [2:0]            ph_ff;
	logic [7:0]            obyte_ff;
	logic [7:0]            stat_lk;
	logic                  link_idle;
	logic                  rd_phase;

	// system domain
	fswp_pkg::fswp_state_t state_ff;
	fswp_pkg::fswp_state_t nxt_state;
	logic [1:0]            pins_s;
	logic                  cs_prev_ff;
	logic                  cs_rise;
	logic                  latch_ff;
	logic                  lock_ff;
	logic [1:0]            guard_ff;
	logic [7:0]            pend_ff;
	logic [7:0]            stat_b;
	logic                  hard_lock;
	logic                  arm_ok;
	logic                  clr_ok;
	logic                  sw_ok;
	logic                  sw_done;
	logic                  arr_ok;
	logic                  arr_done;

	function automatic logic is_op(input fswp_pkg::fswp_frame_t f,
		input logic [7:0] op, input logic [4:0] len);
		is_op = f.op_vld && (f.opcode == op) && (f.bits == len);
	endfunction

	assign link_idle = CS_N | ~ARST_N;

	always_ff @(posedge SPI_CLK or posedge link_idle)
	begin
		if (link_idle)
			first_ff <= 1'b1;
		else
			first_ff <= 1'b0;
	end

	// fields persist past select rise so the system side can judge the frame
	always_ff @(posedge SPI_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			frame_ff <= '0;
			sh_ff    <= '0;
		end
		else if (first_ff)
		begin
			frame_ff        <= '0;
			frame_ff.bits   <= 5'h01;
			sh_ff           <= {6'h00, SERIAL_IN};
		end
		else
		begin
			sh_ff <= {sh_ff[5:0], SERIAL_IN};
			if (frame_ff.bits != fswp_pkg::LEN_SAT)
				frame_ff.bits <= frame_ff.bits + 5'h01;
			if (frame_ff.bits == fswp_pkg::LEN_OP - 5'h01)
			begin
				frame_ff.opcode <= {sh_ff, SERIAL_IN};
				frame_ff.op_vld <= 1'b1;
			end
			if (frame_ff.bits == fswp_pkg::LEN_WR - 5'h01)
				frame_ff.data <= {sh_ff, SERIAL_IN};
		end
	end

	// status copy refreshes on every serial clock rise, the last one half a clock before it is sent
	fswp_sync #(
		.W   (8),
		.RST (fswp_pkg::STAT_RST)
	) u_stat_sync (
		.clk    (SPI_CLK),
		.arst_n (ARST_N),
		.d      (stat_b),
		.q      (stat_lk)
	);

	assign rd_phase = frame_ff.op_vld && (frame_ff.opcode == fswp_pkg::OP_STAT_RD)
		&& (frame_ff.bits >= fswp_pkg::LEN_OP);

	always_ff @(negedge SPI_CLK or posedge link_idle)
	begin
		if (link_idle)
		begin
			SERIAL_OUT_OE_N <= 1'b1;
			ph_ff           <= 3'h0;
		end
		else
		begin
			SERIAL_OUT_OE_N <= ~rd_phase;
			if (rd_phase)
				ph_ff <= ph_ff + 3'h1;
		end
	end

	// a fresh byte is taken every eighth bit so a long read tracks busy
	always_ff @(negedge SPI_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			obyte_ff   <= '0;
			SERIAL_OUT <= 1'b0;
		end
		else if (rd_phase)
		begin
			if (ph_ff == 3'h0)
			begin
				obyte_ff   <= stat_lk;
				SERIAL_OUT <= stat_lk[7];
			end
			else
				SERIAL_OUT <= obyte_ff[3'h7 - ph_ff];
		end
	end

	fswp_sync #(
		.W   (2),
		.RST (8'h03)
	) u_pin_sync (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.d      ({CS_N, LOCK_PIN_N}),
		.q      (pins_s)
	);

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cs_prev_ff <= 1'b1;
		else
			cs_prev_ff <= pins_s[1];
	end

	assign cs_rise   = pins_s[1] & ~cs_prev_ff;
	assign hard_lock = lock_ff & ~pins_s[0];
	assign arm_ok    = cs_rise && is_op(frame_ff, fswp_pkg::OP_ARM, fswp_pkg::LEN_OP);
	assign clr_ok    = cs_rise && is_op(frame_ff, fswp_pkg::OP_CLR, fswp_pkg::LEN_OP);
	assign sw_ok     = cs_rise && is_op(frame_ff, fswp_pkg::OP_STAT_WR, fswp_pkg::LEN_WR)
		&& latch_ff && !hard_lock && (state_ff == fswp_pkg::ST_IDLE);

	// guarded targets refused whenever any guard bit is set, in either lock mode
	always_comb
	begin
		arr_ok = ARRAY_REQ && !sw_ok && latch_ff && (state_ff == fswp_pkg::ST_IDLE);
		if (ARRAY_KIND == fswp_pkg::KIND_FULL)
			arr_ok = arr_ok && (guard_ff == 2'h0);
		else if (ARRAY_IN_GUARD && (guard_ff != 2'h0))
			arr_ok = 1'b0;
	end

	fswp_timer #(
		.CYC (TW_CYCLES)
	) u_tw (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.start  (sw_ok),
		.done   (sw_done)
	);

	assign arr_done = ARRAY_DONE && (state_ff == fswp_pkg::ST_ARR);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			fswp_pkg::ST_IDLE:
			begin
				if (sw_ok)
					nxt_state = fswp_pkg::ST_SWR;
				else if (arr_ok)
					nxt_state = fswp_pkg::ST_ARR;
			end
			fswp_pkg::ST_SWR:
			begin
				if (sw_done)
					nxt_state = fswp_pkg::ST_IDLE;
			end
			fswp_pkg::ST_ARR:
			begin
				if (ARRAY_DONE)
					nxt_state = fswp_pkg::ST_IDLE;
			end
			default:
				nxt_state = fswp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_ff <= fswp_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// setting wins when an arm lands with a completion in the same cycle
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			latch_ff <= 1'b0;
		else if (arm_ok)
			latch_ff <= 1'b1;
		else if (clr_ok || sw_done || arr_done)
			latch_ff <= 1'b0;
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			pend_ff <= '0;
		else if (sw_ok)
			pend_ff <= frame_ff.data;
	end

	// only lock and guard bits take the written byte
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			lock_ff  <= fswp_pkg::LOCK_RST;
			guard_ff <= fswp_pkg::GUARD_RST;
		end
		else if (sw_done)
		begin
			lock_ff  <= pend_ff[fswp_pkg::BIT_LOCK];
			guard_ff <= {pend_ff[fswp_pkg::BIT_GHI], pend_ff[fswp_pkg::BIT_GLO]};
		end
	end

	always_comb
	begin
		stat_b                     = 8'h00;
		stat_b[fswp_pkg::BIT_BUSY]  = (state_ff != fswp_pkg::ST_IDLE);
		stat_b[fswp_pkg::BIT_LATCH] = latch_ff;
		stat_b[fswp_pkg::BIT_GLO]  = guard_ff[0];
		stat_b[fswp_pkg::BIT_GHI]  = guard_ff[1];
		stat_b[fswp_pkg::BIT_LOCK] = lock_ff;
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ARRAY_GRANT  <= 1'b0;
			ARRAY_REFUSE <= 1'b0;
		end
		else
		begin
			ARRAY_GRANT  <= arr_ok;
			ARRAY_REFUSE <= ARRAY_REQ && !arr_ok;
		end
	end

	assign WRITE_LATCH = latch_ff;
	assign WRITE_BUSY  = stat_b[fswp_pkg::BIT_BUSY];
	assign GUARD_SIZE  = guard_ff;
	assign HARD_LOCK   = hard_lock;

	property p_clr;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		clr_ok |=> !latch_ff;
	endproperty
	a_clr: assert property (p_clr) else $error("latch not cleared");

	property p_swend;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		sw_done && !arm_ok |=> !latch_ff && (guard_ff == $past(pend_ff[3:2]));
	endproperty
	a_swend: assert property (p_swend) else $error("bad write completion");

	property p_busy;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		sw_ok |=> stat_b[0] [*2] ##0 (state_ff == fswp_pkg::ST_SWR);
	endproperty
	a_busy: assert property (p_busy) else $error("busy not held");

	property p_wip;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		$rose(stat_b[0]) |-> $past(sw_ok) || $past(arr_ok);
	endproperty
	a_wip: assert property (p_wip) else $error("busy without start");

	property p_grant;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		ARRAY_GRANT |-> $past(latch_ff);
	endproperty
	a_grant: assert property (p_grant) else $error("grant without latch");

	property p_guard;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		ARRAY_GRANT && $past(ARRAY_IN_GUARD) |-> $past(guard_ff) == 2'h0;
	endproperty
	a_guard: assert property (p_guard) else $error("guarded area granted");

	property p_full;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		ARRAY_GRANT && ($past(ARRAY_KIND) == fswp_pkg::KIND_FULL) |-> $past(guard_ff) == 2'h0;
	endproperty
	a_full: assert property (p_full) else $error("full wipe granted");

	property p_lock;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		hard_lock && (state_ff == fswp_pkg::ST_IDLE) |=> state_ff != fswp_pkg::ST_SWR;
	endproperty
	a_lock: assert property (p_lock) else $error("write while locked");

	property p_len;
		@(posedge SYS_CLK) disable iff (!ARST_N)
		$rose(state_ff == fswp_pkg::ST_SWR) |-> $past(frame_ff.bits) == fswp_pkg::LEN_WR;
	endproperty
	a_len: assert property (p_len) else $error("bad write length");
endmodule
`default_nettype wire

// ### pkg/fswp_pkg.sv
// Purpose: constants and types for the flash status and write-protect block
// Assumes: serial link in mode 0, msb first; system clock 10 MHz
// Notes: guard and lock bits are modelled as flops loaded with delivery values
package fswp_pkg;
	localparam logic [7:0] OP_ARM     = 8'h06;
	localparam logic [7:0] OP_CLR     = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;

	localparam int BIT_BUSY  = 0;
	localparam int BIT_LATCH = 1;
	localparam int BIT_GLO   = 2;
	localparam int BIT_GHI   = 3;
	localparam int BIT_LOCK  = 7;

	localparam logic [1:0] GUARD_RST = 2'h0;
	localparam logic       LOCK_RST  = 1'h0;
	localparam logic [7:0] STAT_RST  = 8'h00;

	localparam logic [4:0] LEN_OP   = 5'h08;
	localparam logic [4:0] LEN_WR   = 5'h10;
	localparam logic [4:0] LEN_SAT  = 5'h1f;

	localparam int CLK_KHZ  = 10000;
	localparam int T_W_US   = 5000;
	localparam int TW_CYC   = (T_W_US * CLK_KHZ) / 1000;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] data;
		logic [4:0] bits;
		logic       op_vld;
	} fswp_frame_t;

	typedef enum logic [2:0] {
		KIND_ROW    = 3'h1,
		KIND_REGION = 3'h2,
		KIND_FULL   = 3'h4
	} fswp_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SWR  = 3'h2,
		ST_ARR  = 3'h4
	} fswp_state_t;
endpackage

// ### hw/fswp_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: each bit is an independent slow level
// Notes: bits may land on different edges; no coherence across the vector
`timescale 1ns/10ps
`default_nettype none
module fswp_sync #(
	parameter int         W   = 1,
	parameter logic [7:0] RST = 8'h00
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= RST[W-1:0];
			q       <= RST[W-1:0];
		end
		else
		begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ### hw/fswp_timer.sv
// Purpose: self-timed cycle counter for the status-write cycle
// Assumes: CYC of at least 2
// Notes: done is a one-cycle pulse CYC cycles after start
`timescale 1ns/10ps
`default_nettype none
module fswp_timer #(
	parameter int unsigned CYC = 2
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic start,
	output logic      done
);
	localparam int CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt_ff;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_ff <= '0;
		else if (start)
			cnt_ff <= CW'(CYC);
		else if (cnt_ff != '0)
			cnt_ff <= cnt_ff - CW'(1);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			done <= 1'b0;
		else
			done <= (cnt_ff == CW'(1)) && !start;
	end
endmodule
`default_nettype wire

// ### dv/fswp_host.sv
// Purpose: serial host model driving select, serial clock and data in
// Assumes: mode 0, msb first, serial clock 160 ns only inside frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/10ps
`default_nettype none
module fswp_host (
	output logic      cs_n,
	output logic      sck,
	output logic      mosi,
	input  wire logic miso
);
	initial
	begin
		cs_n = 1'h1;
		sck  = 1'h0;
		mosi = 1'h0;
	end

	// shift n bits of tx msb first; keeps a long idle gap so frames never crowd
	task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h000000;
		cs_n = 1'h0;
		#30;
		for (int i = 0; i < n; i++)
		begin
			mosi = tx[n-1-i];
			#80 sck = 1'h1;
			rx = {rx[22:0], miso};
			#80 sck = 1'h0;
		end
		#30 cs_n = 1'h1;
		mosi = ~mosi;
		#700;
	endtask
endmodule
`default_nettype wire

// ### dv/tb_fswp_top.sv
// Purpose: self-checking bench for the status and write-protect block
// Assumes: short self-timed cycle of 60 system clocks
// Notes: array sequencer side is driven directly by the bench
`timescale 1ns/10ps
`default_nettype none
module tb_fswp_top;
	logic       sys_clk, arst_n, cs_n, sck, mosi, miso, miso_oe_n;
	logic       lock_pin_n, a_req, a_in_guard, a_done, a_grant, a_refuse;
	logic [2:0] a_kind;
	logic       w_latch, w_busy, hard_lock;
	logic [1:0] guard;
	logic       oe_seen;
	int         errors, n_tests;

	fswp_top #(.TW_CYCLES(60)) u_fswp_top (.SYS_CLK(sys_clk), .ARST_N(arst_n),
		.SPI_CLK(sck), .CS_N(cs_n), .SERIAL_IN(mosi), .SERIAL_OUT(miso),
		.SERIAL_OUT_OE_N(miso_oe_n), .LOCK_PIN_N(lock_pin_n), .ARRAY_REQ(a_req),
		.ARRAY_KIND(a_kind), .ARRAY_IN_GUARD(a_in_guard), .ARRAY_DONE(a_done),
		.ARRAY_GRANT(a_grant), .ARRAY_REFUSE(a_refuse), .WRITE_LATCH(w_latch),
		.WRITE_BUSY(w_busy), .GUARD_SIZE(guard), .HARD_LOCK(hard_lock));
	fswp_host u_fswp_host (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));

	// notes whether the data line was driven at any serial clock of a frame
	always @(posedge sck)
	begin
		if (!miso_oe_n)
			oe_seen = 1'h1;
	end

	initial
	begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [15:0] tx, input int n);
		logic [23:0] rx;
		oe_seen = 1'h0;
		u_fswp_host.xfer({8'h00, tx}, n, rx);
		chk(oe_seen, 8'h00);
	endtask

	// two status bytes in one frame: the byte must repeat while selected
	task automatic rd(input logic [7:0] exp);
		logic [23:0] rx;
		oe_seen = 1'h0;
		u_fswp_host.xfer(24'h050000, 24, rx);
		chk(rx[15:8], exp);
		chk(rx[7:0], exp);
		chk({oe_seen, miso_oe_n}, 8'h03);
	endtask

	// samples away from the launching edge so the busy level has settled
	task automatic wait_idle;
		for (int i = 0; i < 200 && w_busy !== 1'h0; i++)
			@(negedge sys_clk);
		chk(w_busy, 8'h00);
	endtask

	task automatic pin(input logic v);
		@(posedge sys_clk) lock_pin_n <= v;
		repeat (4) @(posedge sys_clk);
	endtask

	// one request; a grant must show busy at once, then a done pulse must end busy and the latch
	task automatic areq(input fswp_pkg::fswp_kind_t k, input logic g, input logic ok);
		@(posedge sys_clk)
		begin
			a_req <= 1'h1;
			a_kind <= k;
			a_in_guard <= g;
		end
		@(posedge sys_clk) a_req <= 1'h0;
		#1 chk({a_grant, a_refuse}, {6'h00, ok, ~ok});
		if (ok)
		begin
			chk(w_busy, 8'h01);
			@(posedge sys_clk) a_done <= 1'h1;
			@(posedge sys_clk) a_done <= 1'h0;
			repeat (2) @(posedge sys_clk);
			chk({w_busy, w_latch}, 8'h00);
		end
	endtask

	task automatic t_reset;
		chk({w_latch, w_busy, guard, hard_lock}, 8'h00);
		rd(8'h00);
		$display("test reset done");
	endtask

	task automatic t_latch;
		send(16'h0006, 8);
		chk(w_latch, 8'h01);
		rd(8'h02);
		send(16'h0004, 7);
		chk(w_latch, 8'h01);
		send(16'h0004, 8);
		chk(w_latch, 8'h00);
		send(16'h01ff, 16);
		chk(w_busy, 8'h00);
		$display("test latch done");
	endtask

	task automatic t_stat_wr;
		send(16'h0006, 8);
		send(16'h01ff, 15);
		chk({w_busy, w_latch}, 8'h01);
		send(16'h01ff, 17);
		chk({w_busy, w_latch}, 8'h01);
		send(16'h01ff, 16);
		chk(w_busy, 8'h01);
		rd(8'h03);
		wait_idle();
		chk(w_latch, 8'h00);
		rd(8'h8c);
		$display("test status write done");
	endtask

	task automatic t_array;
		send(16'h0006, 8);
		areq(fswp_pkg::KIND_FULL, 1'h0, 1'h0);
		areq(fswp_pkg::KIND_ROW, 1'h1, 1'h0);
		areq(fswp_pkg::KIND_REGION, 1'h0, 1'h1);
		areq(fswp_pkg::KIND_ROW, 1'h0, 1'h0);
		$display("test array done");
	endtask

	task automatic t_lock;
		chk(hard_lock, 8'h00);
		send(16'h0006, 8);
		pin(1'h0);
		chk(hard_lock, 8'h01);
		send(16'h0100, 16);
		chk({w_busy, guard}, 8'h03);
		send(16'h0004, 8);
		send(16'h0006, 8);
		chk(hard_lock, 8'h01);
		pin(1'h1);
		chk(hard_lock, 8'h00);
		send(16'h0100, 16);
		chk(w_busy, 8'h01);
		wait_idle();
		pin(1'h0);
		send(16'h0006, 8);
		send(16'h0180, 16);
		wait_idle();
		chk({hard_lock, guard}, 8'h04);
		pin(1'h1);
		send(16'h0006, 8);
		areq(fswp_pkg::KIND_FULL, 1'h0, 1'h1);
		send(16'h0006, 8);
		areq(fswp_pkg::KIND_ROW, 1'h1, 1'h1);
		$display("test lock done");
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#500000;
		errors++;
		print_verdict();
	end

	initial
	begin
		errors = 0;
		n_tests = 0;
		arst_n = 1'h0;
		lock_pin_n = 1'h1;
		a_req = 1'h0;
		a_kind = 3'h1;
		a_in_guard = 1'h0;
		a_done = 1'h0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_latch();
		t_stat_wr();
		t_array();
		t_lock();
		print_verdict();
	end
endmodule
`default_nettype wire
